// ---- hdl/sram_burst_ctrl.sv ----
// Purpose: memory controller end of the burst-of-four common-I/O link
// Assumes: makes the link clock pair by dividing mclk
// Notes:   one command at a time; bus turnaround by fixed spacing
`timescale 1ns/1ps
`include "sram_link_map.svh"
module sram_burst_ctrl
  import sram_link_pkg::*;
(
  input  wire logic   mclk,
  input  wire logic   nrst,
  sram_link_if.ctrl   link,
  input  wire logic   cmd_valid,
  input  wire logic   cmd_write,
  input  addr_t       cmd_addr,
  input  burst_t      cmd_wdata,
  input  burst_mask_t cmd_wmask_n,
  input  wire logic   dll_enable,
  output logic        cmd_ready,
  output burst_t      rd_data,
  output logic        rd_valid
);

  typedef struct packed {
    logic [`K_CNT_W-1:0] kcnt;   // position inside one link cycle
    logic                k;
    logic                kn;
    logic                ld_n;
    logic                rw;
    addr_t               addr;
    logic                loop;
    logic [1:0]          gap;    // link cycles left before next command
    logic [`WPH_W-1:0]   wph;    // write data phase, zero when idle
    burst_t              wbuf;
    burst_mask_t         wmask;
    beat_t               dq_out;
    logic                dq_oe;
    mask_t               mask_n;
    logic [1:0]          rbeat;
    burst_t              rbuf;
    logic                rdv;
  } ctl_state_s;

  logic [`DQ_W+2:0] s1_reg;      // first sampling stage of returned pins
  logic [`DQ_W+2:0] s2_reg;
  logic             ep_d_reg;    // delayed echoes for edge finding
  logic             en_d_reg;
  ctl_state_s       st_reg;
  ctl_state_s       st_next;
  logic             s_ep;
  logic             s_en;
  logic             s_vld;
  beat_t            s_dq;
  logic             accept;
  logic [1:0]       wsel;

  assign {s_ep, s_en, s_vld, s_dq} = s2_reg;
  // a command slot is mid-cycle so pins settle before the true rise;
  // an unfinished write data phase blocks the slot
  assign cmd_ready = (st_reg.kcnt == `K_HALF) && (st_reg.gap == 2'h0)
                     && (st_reg.wph == '0);
  assign accept    = cmd_ready && cmd_valid;

  // echoes, valid flag and bus pass two flip-flops
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      ep_d_reg <= 1'b0;
      en_d_reg <= 1'b0;
    end
    else
    begin
      s1_reg   <= {link.echo_strobe_pos, link.echo_strobe_neg, link.read_valid_flag, link.dq};
      s2_reg   <= s1_reg;
      ep_d_reg <= s_ep;
      en_d_reg <= s_en;
    end
  end

  // next state: clock divider, command slot, write beats, read capture
  always_comb
  begin
    st_next = st_reg;
    wsel = 2'h0;
    st_next.rdv  = 1'b0;
    st_next.kcnt = (st_reg.kcnt == `K_LAST) ? '0 : st_reg.kcnt + `K_CNT_W'(1);
    st_next.k    = (st_next.kcnt < `K_HALF);
    st_next.kn   = ~st_next.k;
    st_next.loop = dll_enable;
    // command slot once per link cycle
    if (st_reg.kcnt == `K_HALF)
    begin
      st_next.ld_n = ~accept;
      if (st_reg.gap != 2'h0)
      begin
        st_next.gap = st_reg.gap - 2'h1;
      end
      if (accept)
      begin
        st_next.rw   = ~cmd_write;
        st_next.addr = cmd_addr;
        st_next.gap  = cmd_write ? 2'h0 : `GAP_RD;
        if (cmd_write)
        begin
          st_next.wph   = `WPH_START;
          st_next.wbuf  = cmd_wdata;
          st_next.wmask = cmd_wmask_n;
        end
      end
    end
    // data changes three mclk after each clock rise, one mclk before the next rise
    if ((st_reg.kcnt == `K_Q1 || st_reg.kcnt == `K_Q3) && st_reg.wph != '0)
    begin
      st_next.wph = (st_reg.wph == `WPH_END) ? '0 : st_reg.wph + `WPH_W'(1);
      if (st_next.wph >= `WPH_FIRST && st_next.wph <= `WPH_LAST)
      begin
        wsel = 2'(st_next.wph - `WPH_FIRST);
        st_next.dq_out = st_reg.wbuf[wsel];
        st_next.mask_n = st_reg.wmask[wsel];
        st_next.dq_oe  = 1'b1;
      end
      else
      begin
        st_next.dq_oe  = 1'b0;
        st_next.mask_n = `MASK_NONE;
      end
    end
    // gather read beats on each echo rise while the flag is up
    if (((s_ep && !ep_d_reg) || (s_en && !en_d_reg)) && s_vld)
    begin
      st_next.rbuf[st_reg.rbeat] = s_dq;
      st_next.rbeat = st_reg.rbeat + 2'h1;
      st_next.rdv   = (st_reg.rbeat == `LAST_BEAT);
    end
  end

  // state register; link idles deselected with all lanes masked
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg        <= '0;
      st_reg.kcnt   <= `K_LAST;  // first link clock high phase is full length
      st_reg.kn     <= 1'b1;
      st_reg.ld_n   <= 1'b1;
      st_reg.rw     <= `LVL_READ;
      st_reg.mask_n <= `MASK_NONE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign link.k                 = st_reg.k;
  assign link.k_n               = st_reg.kn;
  assign link.load_select_n     = st_reg.ld_n;
  assign link.read_not_write    = st_reg.rw;
  assign link.sync_address      = st_reg.addr;
  assign link.loop_enable       = st_reg.loop;
  assign link.lane_write_mask_n = st_reg.mask_n;
  assign link.ctl_dq_out        = st_reg.dq_out;
  assign link.ctl_dq_oe         = st_reg.dq_oe;
  assign rd_data                = st_reg.rbuf;
  assign rd_valid               = st_reg.rdv;

endmodule : sram_burst_ctrl

// ---- hdl/sram_burst_device.sv ----
// Purpose: memory device end of the burst-of-four common-I/O link
// Assumes: link pins come from another clock domain, sampled twice by mclk
// Notes:   storage is a small flip-flop window indexed by low address bits
`timescale 1ns/1ps
`include "sram_link_map.svh"
module sram_burst_device
  import sram_link_pkg::*;
(
  input  wire logic   mclk,
  input  wire logic   nrst,
  sram_link_if.device link,
  output logic        write_commit,
  output addr_t       commit_addr
);

  // whole device pipeline state, one register
  typedef struct packed {
    logic                rq_pend;   // read waiting for its latency
    logic [`TICK_W-1:0]  rq_cnt;    // ticks left until first read beat
    addr_t               rq_addr;
    logic                ra_act;    // read beats on the bus
    logic [1:0]          ra_beat;
    addr_t               ra_addr;
    logic                wq_pend;   // write waiting for its first beat
    logic [`TICK_W-1:0]  wq_cnt;
    addr_t               wq_addr;
    logic                wa_act;    // write beats being taken
    logic [1:0]          wa_beat;
    addr_t               wa_addr;
    burst_t              wbuf;      // internal write buffer
    burst_mask_t         wlane;     // lanes really written per beat
    beat_t               dq_out;    // output register
    logic                dq_oe;
    logic                vld;
    logic                commit;    // buffer goes to the core next cycle
    addr_t               commit_addr;
  } dev_state_s;

  typedef burst_t [`MEM_DEPTH-1:0] mem_t;

  logic [`SYNC_W-1:0] s1_reg;       // first sampling stage, read only by s2
  logic [`SYNC_W-1:0] s2_reg;       // second sampling stage
  logic               k_d_reg;      // delayed true clock, also echo
  logic               kn_d_reg;     // delayed complement clock, also echo
  dev_state_s         st_reg;
  dev_state_s         st_next;
  mem_t               mem_reg;
  mem_t               mem_next;

  logic  s_k;                       // sampled pins
  logic  s_kn;
  logic  s_ld_n;
  logic  s_rw;
  logic  s_loop;
  addr_t s_addr;
  mask_t s_mask_n;
  beat_t s_dq;
  logic  k_rise;
  logic  kn_rise;
  logic  tick;

  assign {s_k, s_kn, s_ld_n, s_rw, s_loop, s_addr, s_mask_n, s_dq} = s2_reg;
  assign k_rise  = s_k & ~k_d_reg;
  assign kn_rise = s_kn & ~kn_d_reg;
  assign tick    = k_rise | kn_rise;

  // copy enabled lanes of a new beat over an old one
  function automatic beat_t merge(beat_t old_b, beat_t new_b, mask_t en);
    beat_t r;
    r = old_b;
    for (int l = 0; l < `LANES; l++)
    begin
      if (en[l])
      begin
        r[l*`LANE_W +: `LANE_W] = new_b[l*`LANE_W +: `LANE_W];
      end
    end
    return r;
  endfunction : merge

  // read beat from the core, patched by bytes still held in the buffer
  function automatic beat_t fetch(dev_state_s s, mem_t m, addr_t a, logic [1:0] b);
    beat_t base;
    base = m[a[`MEM_IDX_W-1:0]][b];
    return merge(base, s.wbuf[b], (s.wa_addr == a) ? s.wlane[b] : '0);
  endfunction : fetch

  // two-stage sampling of every link pin; the clocks ride the same path
  // as the data so their relative timing is kept
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      // start at the idle pin levels, so no false complement edge follows reset
      s1_reg   <= `SYNC_IDLE;
      s2_reg   <= `SYNC_IDLE;
      k_d_reg  <= 1'b0;
      kn_d_reg <= 1'b1;
    end
    else
    begin
      s1_reg   <= {link.k, link.k_n, link.load_select_n, link.read_not_write,
                   link.loop_enable, link.sync_address, link.lane_write_mask_n, link.dq};
      s2_reg   <= s1_reg;
      k_d_reg  <= s_k;
      kn_d_reg <= s_kn;
    end
  end

  // pipeline next state: commands, write capture, read launch
  always_comb
  begin
    logic [1:0] wb;
    wb = st_reg.wa_beat;
    st_next = st_reg;
    st_next.commit = 1'b0;
    if (tick)
    begin
      // active read moves one beat per tick, ends after beat four
      if (st_reg.ra_act)
      begin
        st_next.ra_beat = st_reg.ra_beat + 2'h1;
        if (st_reg.ra_beat == `LAST_BEAT)
        begin
          st_next.ra_act = 1'b0;
        end
      end
      // queued read becomes active once its latency has run out
      if (st_reg.rq_pend)
      begin
        st_next.rq_cnt = st_reg.rq_cnt - `TICK_ONE;
        if (st_reg.rq_cnt == `TICK_ONE)
        begin
          st_next.rq_pend = 1'b0;
          st_next.ra_act  = 1'b1;
          st_next.ra_beat = 2'h0;
          st_next.ra_addr = st_reg.rq_addr;
        end
      end
      // queued write starts on the true rise one cycle after its command
      if (st_reg.wq_pend && st_reg.wq_cnt == `TICK_ONE)
      begin
        st_next.wq_pend = 1'b0;
        st_next.wa_act  = 1'b1;
        st_next.wa_addr = st_reg.wq_addr;
        st_next.wlane   = '0;
        wb = 2'h0;
      end
      else if (st_reg.wq_pend)
      begin
        st_next.wq_cnt = st_reg.wq_cnt - `TICK_ONE;
      end
      // take one write beat and its lane mask into the buffer
      if (st_next.wa_act)
      begin
        st_next.wbuf[wb]  = s_dq;
        st_next.wlane[wb] = ~s_mask_n;
        if (wb == `LAST_BEAT)
        begin
          st_next.wa_act      = 1'b0;
          st_next.commit      = 1'b1;
          st_next.commit_addr = st_next.wa_addr;
        end
        else
        begin
          st_next.wa_beat = wb + 2'h1;
        end
      end
      // commands only on a true rise while selected; falls and the
      // complement rise carry no command, deselect ignores the address
      if (k_rise && !s_ld_n)
      begin
        if (s_rw == `LVL_READ)
        begin
          st_next.rq_pend = 1'b1;
          st_next.rq_cnt  = s_loop ? `RD_LEAD_DLL : `RD_LEAD_BYP;
          st_next.rq_addr = s_addr;
        end
        else
        begin
          st_next.wq_pend = 1'b1;
          st_next.wq_cnt  = `WR_LEAD;
          st_next.wq_addr = s_addr;
        end
      end
      // output register: drive only during read beats
      st_next.dq_oe = st_next.ra_act;
      st_next.vld   = st_next.ra_act;
      if (st_next.ra_act)
      begin
        st_next.dq_out = fetch(st_reg, mem_reg, st_next.ra_addr, st_next.ra_beat);
      end
    end
  end

  // pipeline register
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // late write: the buffer lands in the core one cycle after its last
  // beat; forwarding covers reads in that gap
  always_comb
  begin
    mem_next = mem_reg;
    if (st_reg.commit)
    begin
      for (int b = 0; b < `BEATS; b++)
      begin
        mem_next[st_reg.commit_addr[`MEM_IDX_W-1:0]][b] =
          merge(mem_reg[st_reg.commit_addr[`MEM_IDX_W-1:0]][b], st_reg.wbuf[b],
                st_reg.wlane[b]);
      end
    end
  end

  // core storage
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      mem_reg <= '0;
    end
    else
    begin
      mem_reg <= mem_next;
    end
  end

  // echoes are the delayed clocks, so their edges land with the data
  assign link.echo_strobe_pos = k_d_reg;
  assign link.echo_strobe_neg = kn_d_reg;
  assign link.read_valid_flag = st_reg.vld;
  assign link.dev_dq_out      = st_reg.dq_out;
  assign link.dev_dq_oe       = st_reg.dq_oe;
  assign write_commit         = st_reg.commit;
  assign commit_addr          = st_reg.commit_addr;

endmodule : sram_burst_device

// ---- hdl/sram_link_if.sv ----
// Purpose: pins between memory controller and memory device
// Assumes: both ends clocked by their own mclk
// Notes:   shared data bus resolved from the two enables
`timescale 1ns/1ps
interface sram_link_if;
  import sram_link_pkg::*;
  logic  k;                  // true link clock
  logic  k_n;                // complementary link clock
  logic  load_select_n;      // low selects a command
  logic  read_not_write;     // high read, low write
  logic  loop_enable;        // low bypasses the delay loop
  addr_t sync_address;       // burst address
  mask_t lane_write_mask_n;  // low enables a lane
  logic  echo_strobe_pos;    // echo of true clock
  logic  echo_strobe_neg;    // echo of complement clock
  logic  read_valid_flag;    // read beat on the bus
  beat_t ctl_dq_out;         // controller drive value
  logic  ctl_dq_oe;          // controller drives bus
  beat_t dev_dq_out;         // device drive value
  logic  dev_dq_oe;          // device drives bus
  beat_t dq;                 // resolved bus level

  // device wins on a clash; an undriven bus reads zero
  assign dq = dev_dq_oe ? dev_dq_out : (ctl_dq_oe ? ctl_dq_out : '0);

  modport device (input k, k_n, load_select_n, read_not_write, loop_enable, sync_address,
                  lane_write_mask_n, dq, output echo_strobe_pos, echo_strobe_neg,
                  read_valid_flag, dev_dq_out, dev_dq_oe);
  modport ctrl (output k, k_n, load_select_n, read_not_write, loop_enable, sync_address,
                lane_write_mask_n, ctl_dq_out, ctl_dq_oe, input echo_strobe_pos,
                echo_strobe_neg, read_valid_flag, dq);
endinterface : sram_link_if

// ---- hdl/sram_link_map.svh ----
// Purpose: shared constants for the burst-of-four common-I/O memory link
// Assumes: included by the package and by both ends; guarded
// Notes:   tick = one rising edge of either link clock (half a link cycle)
`ifndef SRAM_LINK_MAP_SVH
`define SRAM_LINK_MAP_SVH

`define DQ_W        36
`define LANES       4
`define LANE_W      9
`define ADDR_W      19
`define BEATS       4
`define LAST_BEAT   2'h3
`define MEM_IDX_W   4
`define MEM_DEPTH   16
`define SYNC_W      (5 + `ADDR_W + `LANES + `DQ_W)
// idle pin levels in sampling order: k low, k_n high, deselected, read, masked
`define SYNC_IDLE   {1'b0, 1'b1, 1'b1, `LVL_READ, 1'b0, {`ADDR_W{1'b0}}, `MASK_NONE, {`DQ_W{1'b0}}}
`define LVL_READ    1'b1
`define MASK_NONE   4'hF

`define MCLK_NS     25
`define K_PERIOD_NS 200
`define K_CNT_W     3
`define K_LAST      (`K_CNT_W'(`K_PERIOD_NS / `MCLK_NS - 1))
`define K_HALF      (`K_CNT_W'(`K_PERIOD_NS / `MCLK_NS / 2))
`define K_Q1        (`K_CNT_W'(`K_PERIOD_NS / `MCLK_NS / 4))
`define K_Q3        (`K_CNT_W'(3 * `K_PERIOD_NS / `MCLK_NS / 4))

`define TICK_W      3
`define TICK_ONE    3'h1
`define WR_LEAD     3'h2
`define RD_LEAD_DLL 3'h4
`define RD_LEAD_BYP 3'h2
`define GAP_RD      2'h3
`define WPH_W       4
`define WPH_START   4'h1
`define WPH_FIRST   4'h4
`define WPH_LAST    4'h7
`define WPH_END     4'h8

`endif

// ---- hdl/sram_link_pkg.sv ----
// Purpose: shared types of the memory link
// Assumes: constants come from the map header
// Notes:   one burst is four beats of 36 bits
package sram_link_pkg;
`include "sram_link_map.svh"
  typedef logic [`DQ_W-1:0]   beat_t;        // one data beat, fixed 36 bits
  typedef logic [`LANES-1:0]  mask_t;        // one bit per byte lane
  typedef logic [`ADDR_W-1:0] addr_t;        // burst address
  typedef beat_t [`BEATS-1:0] burst_t;       // four beats, beat 0 lowest
  typedef mask_t [`BEATS-1:0] burst_mask_t;  // lane bits per beat
endpackage : sram_link_pkg

// ---- sim/ddr_burst4_cio_sram_port_tb.sv ----
// Purpose: self-checking bench joining the controller end and the device end
// Assumes: both ends share mclk; the controller divides it into the link clock
// Notes:   a mirror of the core predicts read bursts and commit addresses
`timescale 1ns/1ps
module ddr_burst4_cio_sram_port_tb;
  import sram_link_pkg::*;
  logic        mclk;          // system clock
  logic        nrst;          // active low reset
  logic        cmd_valid;     // user request
  logic        cmd_write;     // high for a write
  addr_t       cmd_addr;      // burst address
  burst_t      cmd_wdata;     // write burst
  burst_mask_t cmd_wmask_n;   // lane masks, low writes
  logic        dll_enable;    // delay loop on
  logic        cmd_ready;     // request taken when high
  burst_t      rd_data;       // returned read burst
  logic        rd_valid;      // read burst present
  logic        write_commit;  // burst goes to the core next cycle
  addr_t       commit_addr;   // address of that burst
  burst_t      mirror [16];   // expected core; high address bits alias
  burst_t      rd_q [$];      // expected read bursts, oldest first
  addr_t       wr_q [$];      // expected commit addresses
  int          err_total;     // mismatches
  int          check_count;   // comparisons

  sram_link_if link ();
  sram_burst_ctrl sram_burst_ctrl_i (
    .mclk(mclk), .nrst(nrst), .link(link), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_wmask_n(cmd_wmask_n), .dll_enable(dll_enable), .cmd_ready(cmd_ready),
    .rd_data(rd_data), .rd_valid(rd_valid)
  );
  sram_burst_device sram_burst_device_i (
    .mclk(mclk), .nrst(nrst), .link(link),
    .write_commit(write_commit), .commit_addr(commit_addr)
  );
  sram_link_asserts sram_link_asserts_i (
    .mclk(mclk), .nrst(nrst), .k(link.k), .k_n(link.k_n),
    .load_select_n(link.load_select_n), .read_not_write(link.read_not_write),
    .loop_enable(link.loop_enable), .lane_write_mask_n(link.lane_write_mask_n),
    .echo_strobe_pos(link.echo_strobe_pos), .echo_strobe_neg(link.echo_strobe_neg),
    .read_valid_flag(link.read_valid_flag), .ctl_dq_oe(link.ctl_dq_oe),
    .dev_dq_oe(link.dev_dq_oe)
  );

  // 40 MHz system clock
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // one place for every comparison
  task automatic compare(input logic [143:0] seen, input logic [143:0] want);
    check_count++;
    if (seen !== want)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : compare

  // the only exit of the run
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // random burst; the cast drops the upper bits on purpose
  function automatic burst_t rnd_burst();
    burst_t r;
    for (int b = 0; b < 4; b++)
      r[b] = beat_t'({$urandom(), $urandom()});
    return r;
  endfunction : rnd_burst

  // hold the request until a ready edge takes it, then note the outcome
  task automatic issue(input logic wr, input addr_t a, input burst_t d, input burst_mask_t m);
    int n;
    @(posedge mclk);
    cmd_valid   <= 1'b1;
    cmd_write   <= wr;
    cmd_addr    <= a;
    cmd_wdata   <= d;
    cmd_wmask_n <= m;
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (cmd_ready !== 1'b1 && n < 300);
    if (n >= 300)
    begin
      err_total++;
      conclude();
    end
    if (wr)
    begin
      // only lanes whose mask bit is low change, beat by beat
      for (int b = 0; b < 4; b++)
        for (int l = 0; l < 4; l++)
          if (!m[b][l])
            mirror[a[3:0]][b][9*l +: 9] = d[b][9*l +: 9];
      wr_q.push_back(a);
    end
    else
      rd_q.push_back(mirror[a[3:0]]);
    @(posedge mclk);
    cmd_valid <= 1'b0;
  endtask : issue

  // random mix, addresses over the full range so aliasing is exercised
  task automatic mix(input int ops);
    for (int i = 0; i < ops; i++)
      issue(1'($urandom()), addr_t'($urandom()), rnd_burst(), burst_mask_t'($urandom()));
  endtask : mix

  // wait, bounded, until every noted result has been seen
  task automatic drain;
    int n;
    n = 0;
    while ((rd_q.size() != 0 || wr_q.size() != 0) && n < 400)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 400)
    begin
      err_total++;
      conclude();
    end
  endtask : drain

  // results are compared in request order; negedge keeps clear of updates
  always @(negedge mclk)
  begin
    if (rd_valid === 1'b1)
    begin
      if (rd_q.size() != 0)
        compare(rd_data, rd_q.pop_front());
      else
        compare(rd_data, ~rd_data);
    end
    if (write_commit === 1'b1)
    begin
      if (wr_q.size() != 0)
        compare(144'(commit_addr), 144'(wr_q.pop_front()));
      else
        compare(144'(commit_addr), ~144'(commit_addr));
    end
  end

  initial
  begin
    burst_t d;
    int     s;
    err_total   = 0;
    check_count = 0;
    nrst        = 1'b0;
    cmd_valid   = 1'b0;
    cmd_write   = 1'b0;
    cmd_addr    = '0;
    cmd_wdata   = '0;
    cmd_wmask_n = '1;
    dll_enable  = 1'b1;
    foreach (mirror[i])
      mirror[i] = '0;
    s = $urandom(32'h1A376333);
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    // untouched location reads back zero
    issue(1'b0, 19'h00005, '0, '1);
    // full write, partial overwrite, read straight after: newest bytes win
    issue(1'b1, 19'h00003, rnd_burst(), '0);
    d = rnd_burst();
    issue(1'b1, 19'h40003, d, 16'hA5C3);
    issue(1'b0, 19'h00003, '0, '1);
    // all lanes masked leaves the core as it was
    issue(1'b1, 19'h00003, ~d, 16'hFFFF);
    issue(1'b0, 19'h00003, '0, '1);
    mix(12);
    drain();
    // delay loop bypassed: shorter latency, same data
    dll_enable <= 1'b0;
    repeat (16) @(posedge mclk);
    mix(8);
    issue(1'b0, 19'h00003, '0, '1);
    drain();
    conclude();
  end
endmodule : ddr_burst4_cio_sram_port_tb

// ---- sim/sram_link_asserts.sv ----
// Purpose: link-level checks between the controller end and the device end
// Assumes: watches the shared interface pins, all sampled on mclk
// Notes:   figures are mclk cycles; one link cycle is 8 mclk
`timescale 1ns/1ps
module sram_link_asserts
(
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       k,
  input wire logic       k_n,
  input wire logic       load_select_n,
  input wire logic       read_not_write,
  input wire logic       loop_enable,
  input wire logic [3:0] lane_write_mask_n,
  input wire logic       echo_strobe_pos,
  input wire logic       echo_strobe_neg,
  input wire logic       read_valid_flag,
  input wire logic       ctl_dq_oe,
  input wire logic       dev_dq_oe
);
  logic [4:0] gap_reg;   // idle cycles since the last command select
  logic [4:0] gap_next;  // next value of the idle count

  // saturating count, preset in reset so the first command is legal
  always_comb
  begin
    gap_next = gap_reg;
    if (!load_select_n)
      gap_next = 5'h00;
    else if (gap_reg != 5'h1F)
      gap_next = gap_reg + 5'h01;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      gap_reg <= 5'h1F;
    else
      gap_reg <= gap_next;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  clock_pair_a: assert property (k_n == !k)
    else $error("link clocks not complementary");
  clock_period_a: assert property ($rose(k) |-> k[*4] ##1 (!k)[*4] ##1 k)
    else $error("link clock period wrong");
  cmd_spacing_a: assert property ($fell(load_select_n) |-> gap_reg >= 5'h10)
    else $error("commands too close");
  select_len_a: assert property ($fell(load_select_n) |-> (!load_select_n)[*8] ##1 load_select_n)
    else $error("select not one link cycle");
  write_start_a: assert property ($rose(k) && !load_select_n && !read_not_write
    |-> ##7 $rose(ctl_dq_oe))
    else $error("write data late");
  write_burst_a: assert property ($rose(ctl_dq_oe) |-> ctl_dq_oe[*8] ##1 ctl_dq_oe[*8] ##1 !ctl_dq_oe)
    else $error("write burst not four beats");
  idle_mask_a: assert property (!ctl_dq_oe |-> lane_write_mask_n == 4'hF)
    else $error("lane mask active while idle");
  read_lat_a: assert property ($rose(k) && !load_select_n && read_not_write && loop_enable
    |-> ##[17:21] $rose(read_valid_flag))
    else $error("read latency wrong");
  bypass_lat_a: assert property ($rose(k) && !load_select_n && read_not_write && !loop_enable
    |-> ##[9:13] $rose(read_valid_flag))
    else $error("bypass latency wrong");
  valid_len_a: assert property ($rose(read_valid_flag)
    |-> read_valid_flag[*8] ##1 read_valid_flag[*8] ##1 !read_valid_flag)
    else $error("valid flag not four beats");
  bus_owner_a: assert property (dev_dq_oe |-> read_valid_flag && !ctl_dq_oe)
    else $error("device drives outside a read");
  echo_track_a: assert property (echo_strobe_pos == $past(k, 3))
    else $error("echo clock off track");
  echo_pair_a: assert property ($rose(echo_strobe_pos) |-> !echo_strobe_neg)
    else $error("echo clocks not paired");

  cover property ($rose(ctl_dq_oe));
  cover property ($rose(read_valid_flag) && loop_enable);
  cover property ($rose(read_valid_flag) && !loop_enable);
endmodule : sram_link_asserts
